// [shared/modem_defines.svh]
// Constants for the per-line modem control and status block
`ifndef MODEM_DEFINES_SVH
`define MODEM_DEFINES_SVH

// ****************************************
// Register select codes
// ****************************************
`define SEL_SCAN_CTRL   3'h0
`define SEL_LINE_MODEM  3'h1
`define SEL_SEC_ADDR    3'h2
`define SEL_SEC_SELECT  3'h3
`define SEL_SYS_CTRL    3'h4

// ****************************************
// Scan control register fields
// ****************************************
`define CSR_LINE_LO     0
`define CSR_LINE_HI     3
`define CSR_SCAN_EN     5
`define CSR_DONE        7
`define CSR_STEP        8
`define CSR_MUX_CLR     10
`define CSR_CLR_SCAN    11
`define CSR_TRANS_LO    12
`define CSR_TRANS_HI    15

// ****************************************
// Line modem and system control register fields
// ****************************************
`define LMR_GATE        0
`define LMR_SEIZE       1
`define LMR_SEND_REQ    2
`define LMR_BIT3        3
`define LMR_STAT_LO     4
`define LMR_STAT_HI     7
`define STAT_RING       3
`define SCR_GO          0

// ****************************************
// Reset values and timing
// ****************************************
`define LINE_RST        4'h0
`define STAT_RST        4'h0
`define CLK_PERIOD_NS   100
`define SCAN_STEP_NS    1200
`define SCAN_STEP_CYC   ((`SCAN_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// [shared/modem_pkg.sv]
// Types shared by the modem control and status block
`default_nettype none
package modem_pkg;
    typedef enum logic [2:0] {
        SCAN_IDLE  = 3'h1,
        SCAN_WAIT  = 3'h2,
        SCAN_CHECK = 3'h4
    } scan_state_type;
    typedef logic [3:0] line_num_type;
    typedef logic [3:0] stat_type;
endpackage : modem_pkg
`default_nettype wire

// [shared/sec_ram_if.sv]
// Port bundle between the register logic and the secondary RAM
`default_nettype none
interface sec_ram_if #(parameter int AW = 8, parameter int DW = 16);
    logic          wr_en;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic [DW-1:0] rdata;
    modport mem  (input wr_en, addr, wdata, output rdata);
    modport user (output wr_en, addr, wdata, input rdata);
endinterface : sec_ram_if
`default_nettype wire

// [core/sec_ram.sv]
// Secondary register RAM with registered read data
`default_nettype none
module sec_ram #(
    parameter int AW = 8,
    parameter int DW = 16
) (
    input wire logic ref_clk_in,
    sec_ram_if.mem   ram
);
    logic [DW-1:0] words [0:(1<<AW)-1];

    // Write port; contents are volatile and not cleared by reset
    always_ff @(posedge ref_clk_in) begin
        if (ram.wr_en) begin
            words[ram.addr] <= ram.wdata;
        end
    end

    // Read data from a register, one cycle after the address
    always_ff @(posedge ref_clk_in) begin
        ram.rdata <= words[ram.addr];
    end
endmodule : sec_ram
`default_nettype wire

// [core/scan_tick_gen.sv]
// Divider giving one scan step pulse per step period
`default_nettype none
module scan_tick_gen #(
    parameter int DIV = 12
) (
    input  wire logic ref_clk_in,
    input  wire logic sys_rst_in,
    input  wire logic run_in,
    output logic      tick_out
);
    localparam int CW = $clog2(DIV + 1);
    logic [CW-1:0] cnt_ff;

    if (DIV < 1) begin : g_chk
        $error("scan_tick_gen: DIV must be at least one");
    end

    // Count restarts whenever the scanner is not waiting
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in || !run_in) begin
            cnt_ff   <= '0;
            tick_out <= 1'b0;
        end else if (cnt_ff == CW'(DIV - 1)) begin
            cnt_ff   <= '0;
            tick_out <= 1'b1;
        end else begin
            cnt_ff   <= cnt_ff + CW'(1);
            tick_out <= 1'b0;
        end
    end
endmodule : scan_tick_gen
`default_nettype wire

// [core/per_line_modem_control_status.sv]
// Per-line modem control and status registers with modem scanner
`include "modem_defines.svh"
`default_nettype none
module per_line_modem_control_status
    import modem_pkg::*;
#(
    parameter int NUM_LINES     = 16,
    parameter int REGS_PER_LINE = 16
) (
    input  wire logic        ref_clk_in,
    input  wire logic        sys_rst_in,
    input  wire logic [2:0]  reg_sel_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    input  wire logic [15:0] reg_wdata_in,
    output logic      [15:0] reg_rdata_out,
    input  wire logic [15:0] modem_dsr_in,
    input  wire logic [15:0] modem_reverse_rx_in,
    input  wire logic [15:0] modem_cts_in,
    input  wire logic [15:0] modem_carrier_in,
    input  wire logic [15:0] modem_ring_in,
    input  wire logic [15:0] line_async_in,
    output logic      [15:0] terminal_ready_out,
    output logic      [15:0] send_request_out,
    output logic      [15:0] carrier_resync_out,
    output logic      [15:0] reverse_channel_transmit_out,
    output logic             seq_go_out,
    output logic             scan_done_out
);
    // ****************************************
    // Parameter checks
    // ****************************************
    if (NUM_LINES != 16 || REGS_PER_LINE != 16) begin : g_chk
        $error("line field and RAM address need 16 lines of 16 words");
    end

    localparam int AW = $clog2(NUM_LINES * REGS_PER_LINE);

    // ****************************************
    // Declarations
    // ****************************************
    logic [95:0]          sync1_ff;
    logic [95:0]          sync2_ff;
    logic [15:0]          dsr_s, rrx_s, cts_s, car_s, ring_s, async_s;
    logic [15:0]          gate_ff, seize_ff, send_req_ff, bit3_ff;
    stat_type             stat [0:15];
    stat_type             scan_mem_ff [0:15];
    line_num_type         line_ff;
    logic                 scan_en_ff, done_ff, step_chk_ff, go_ff;
    logic [3:0]           trans_ff;
    logic [AW-1:0]        sec_addr_ff;
    scan_state_type       state_ff, nxt_state;
    logic                 tick;
    logic                 wr_csr, wr_lmr, wr_sar, wr_srs, wr_scr;
    logic                 mux_clr, clr_scan, step;
    logic                 check, changed;
    stat_type             diff;
    stat_type             cur;

    sec_ram_if #(.AW(AW), .DW(16)) ram_bus ();

    // ****************************************
    // Pin synchronisers
    // ****************************************
    // Two flops on every modem pin and mode strap
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
        end else begin
            sync1_ff <= {line_async_in, modem_ring_in, modem_carrier_in,
                         modem_cts_in, modem_reverse_rx_in, modem_dsr_in};
            sync2_ff <= sync1_ff;
        end
    end

    assign dsr_s   = sync2_ff[15:0];
    assign rrx_s   = sync2_ff[31:16];
    assign cts_s   = sync2_ff[47:32];
    assign car_s   = sync2_ff[63:48];
    assign ring_s  = sync2_ff[79:64];
    assign async_s = sync2_ff[95:80];

    // ****************************************
    // Gated status per line
    // ****************************************
    // Status appears only while the line's gate is set
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            stat[i] = gate_ff[i] ? {ring_s[i], car_s[i], cts_s[i],
                                    async_s[i] ? rrx_s[i] : dsr_s[i]}
                                 : `STAT_RST;
        end
    end

    // ****************************************
    // Access decode
    // ****************************************
    assign wr_csr   = reg_wr_in && (reg_sel_in == `SEL_SCAN_CTRL);
    assign wr_lmr   = reg_wr_in && (reg_sel_in == `SEL_LINE_MODEM);
    assign wr_sar   = reg_wr_in && (reg_sel_in == `SEL_SEC_ADDR);
    assign wr_srs   = reg_wr_in && (reg_sel_in == `SEL_SEC_SELECT);
    assign wr_scr   = reg_wr_in && (reg_sel_in == `SEL_SYS_CTRL);
    assign mux_clr  = wr_csr && reg_wdata_in[`CSR_MUX_CLR];
    assign clr_scan = wr_csr && reg_wdata_in[`CSR_CLR_SCAN];
    assign step     = wr_csr && reg_wdata_in[`CSR_STEP];

    // ****************************************
    // Per-line modem controls
    // ****************************************
    // Writes land only on the line held in the scan register
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in || mux_clr) begin
            gate_ff     <= '0;
            seize_ff    <= '0;
            send_req_ff <= '0;
            bit3_ff     <= '0;
        end else if (wr_lmr) begin
            gate_ff[line_ff]     <= reg_wdata_in[`LMR_GATE];
            seize_ff[line_ff]    <= reg_wdata_in[`LMR_SEIZE];
            send_req_ff[line_ff] <= reg_wdata_in[`LMR_SEND_REQ];
            bit3_ff[line_ff]     <= reg_wdata_in[`LMR_BIT3];
        end
    end

    // Modem control pins, bit 3 steered by the line's mode
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            terminal_ready_out           <= '0;
            send_request_out             <= '0;
            carrier_resync_out           <= '0;
            reverse_channel_transmit_out <= '0;
        end else begin
            terminal_ready_out           <= seize_ff;
            send_request_out             <= send_req_ff;
            carrier_resync_out           <= bit3_ff & ~async_s;
            reverse_channel_transmit_out <= bit3_ff & async_s;
        end
    end

    // ****************************************
    // Scanner
    // ****************************************
    // Compare the current line against its remembered status
    assign check   = (state_ff == SCAN_CHECK) || step_chk_ff;
    assign cur     = stat[line_ff];
    assign diff    = (cur ^ scan_mem_ff[line_ff]) &
                     {cur[`STAT_RING], 3'h7};           // Ring counts rising only
    assign changed = check && (diff != `STAT_RST);

    // Scan sequencing; stops while done is set
    always_comb begin
        case (state_ff)
            SCAN_IDLE:  nxt_state = (scan_en_ff && !done_ff) ? SCAN_WAIT : SCAN_IDLE;
            SCAN_WAIT:  nxt_state = (!scan_en_ff || done_ff) ? SCAN_IDLE :
                                    (tick ? SCAN_CHECK : SCAN_WAIT);
            SCAN_CHECK: nxt_state = SCAN_IDLE;
            default:    nxt_state = SCAN_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in || clr_scan) begin
            state_ff <= SCAN_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    scan_tick_gen #(.DIV(`SCAN_STEP_CYC)) u_tick (
        .ref_clk_in (ref_clk_in),
        .sys_rst_in (sys_rst_in),
        .run_in     (state_ff == SCAN_WAIT),
        .tick_out   (tick)
    );

    // A step checks the newly selected line one cycle later
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in || clr_scan) begin
            step_chk_ff <= 1'b0;
        end else begin
            step_chk_ff <= step;
        end
    end

    // Remembered status per line, wiped by a scan clear
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in || clr_scan) begin
            for (int i = 0; i < 16; i++) begin
                scan_mem_ff[i] <= `STAT_RST;
            end
        end else if (check) begin
            scan_mem_ff[line_ff] <= cur;
        end
    end

    // Line number: loaded by a write without step, else advanced by a step or by a scan that finds no change
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in || clr_scan) begin
            line_ff <= `LINE_RST;
        end else if (wr_csr && !step) begin
            line_ff <= reg_wdata_in[`CSR_LINE_HI:`CSR_LINE_LO];
        end else if (step) begin
            line_ff <= line_ff + 4'h1;
        end else if (state_ff == SCAN_CHECK && !changed) begin
            line_ff <= line_ff + 4'h1;
        end
    end

    // Done flag and transitions; a change beats a clearing write
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in || clr_scan) begin
            done_ff  <= 1'b0;
            trans_ff <= `STAT_RST;
        end else if (changed) begin
            done_ff  <= 1'b1;
            trans_ff <= diff;
        end else if (wr_csr) begin
            done_ff  <= reg_wdata_in[`CSR_DONE];
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in || clr_scan) begin
            scan_en_ff <= 1'b0;
        end else if (wr_csr) begin
            scan_en_ff <= reg_wdata_in[`CSR_SCAN_EN];
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            scan_done_out <= 1'b0;
        end else begin
            scan_done_out <= done_ff;
        end
    end

    // ****************************************
    // Secondary RAM and system control
    // ****************************************
    // RAM is reached only through address and select registers
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            sec_addr_ff <= '0;
        end else if (wr_sar) begin
            sec_addr_ff <= reg_wdata_in[AW-1:0];
        end
    end

    assign ram_bus.wr_en = wr_srs;
    assign ram_bus.addr  = sec_addr_ff;
    assign ram_bus.wdata = reg_wdata_in;

    sec_ram #(.AW(AW), .DW(16)) u_ram (
        .ref_clk_in (ref_clk_in),
        .ram        (ram_bus.mem)
    );

    // Sequencer go bit; RAM setup before it is software's job
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            go_ff      <= 1'b0;
            seq_go_out <= 1'b0;
        end else begin
            if (wr_scr) begin
                go_ff <= reg_wdata_in[`SCR_GO];
            end
            seq_go_out <= go_ff;
        end
    end

    // ****************************************
    // Read data
    // ****************************************
    // Read data registered; unmapped selects read zero
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            reg_rdata_out <= '0;
        end else if (reg_rd_in) begin
            case (reg_sel_in)
                `SEL_SCAN_CTRL:  reg_rdata_out <= {trans_ff, 4'h0, done_ff, 1'b0,
                                                   scan_en_ff, 1'b0, line_ff};
                `SEL_LINE_MODEM: reg_rdata_out <= {8'h00, cur,
                                                   bit3_ff[line_ff],
                                                   send_req_ff[line_ff],
                                                   seize_ff[line_ff],
                                                   gate_ff[line_ff]};
                `SEL_SEC_ADDR:   reg_rdata_out <= 16'(sec_addr_ff);
                `SEL_SEC_SELECT: reg_rdata_out <= ram_bus.rdata;
                `SEL_SYS_CTRL:   reg_rdata_out <= {15'h0000, go_ff};
                default:         reg_rdata_out <= 16'h0000;
            endcase
        end
    end
endmodule : per_line_modem_control_status
`default_nettype wire

// [testbench/modem_bank_model.sv]
// Behavioural bank of sixteen modems facing the block
`default_nettype none
module modem_bank_model #(
    parameter int CTS_DLY = 3
) (
    input  wire logic        ref_clk_in,
    input  wire logic [15:0] terminal_ready_in,
    input  wire logic [15:0] send_request_in,
    input  wire logic [15:0] carrier_on_in,
    input  wire logic [15:0] ring_on_in,
    input  wire logic [15:0] reverse_on_in,
    output logic      [15:0] dsr_out,
    output logic      [15:0] cts_out,
    output logic      [15:0] carrier_out,
    output logic      [15:0] ring_out,
    output logic      [15:0] reverse_rx_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] rts_dly_ff [CTS_DLY];

    // Send request settles for a few cycles before the modem answers
    always_ff @(posedge ref_clk_in) begin
        rts_dly_ff[0] <= send_request_in;
        for (int i = 1; i < CTS_DLY; i++) begin
            rts_dly_ff[i] <= rts_dly_ff[i-1];
        end
    end

    // Clear to send drops at once when the request goes away
    assign cts_out = rts_dly_ff[CTS_DLY-1] & send_request_in;
    // A seized line shows data set ready
    assign dsr_out = terminal_ready_in;
    assign carrier_out = carrier_on_in;
    assign ring_out = ring_on_in;
    assign reverse_rx_out = reverse_on_in;
endmodule : modem_bank_model
`default_nettype wire

// [testbench/modem_ctl_asserts.sv]
// Port-level checks for the modem control and status block
`default_nettype none
module modem_ctl_asserts #(
    parameter int NUM_LINES     = 16,
    parameter int REGS_PER_LINE = 16
) (
    input wire logic        ref_clk_in,
    input wire logic        sys_rst_in,
    input wire logic [2:0]  reg_sel_in,
    input wire logic        reg_wr_in,
    input wire logic        reg_rd_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic [15:0] reg_rdata_out,
    input wire logic [15:0] terminal_ready_out,
    input wire logic [15:0] send_request_out,
    input wire logic [15:0] carrier_resync_out,
    input wire logic [15:0] reverse_channel_transmit_out,
    input wire logic        seq_go_out,
    input wire logic        scan_done_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);

    // Decoded writes and the union of all control outputs
    wire logic        csr_wr  = reg_wr_in && (reg_sel_in == 3'h0);
    wire logic        sys_wr  = reg_wr_in && (reg_sel_in == 3'h4);
    wire logic        mux_clr = csr_wr && reg_wdata_in[10];
    wire logic [15:0] ctl_any = terminal_ready_out | send_request_out
                              | carrier_resync_out | reverse_channel_transmit_out;

    sequence quiet_bus;
        !reg_wr_in [*3];
    endsequence
    sequence line_read;
        reg_rd_in && (reg_sel_in == 3'h1);
    endsequence

    a_reset_clears: assert property (disable iff (1'b0)
        sys_rst_in [*3] |-> ctl_any == 16'h0 && !seq_go_out && !scan_done_out)
        else $error("outputs not cleared under reset");
    a_bit3_exclusive: assert property (
        (carrier_resync_out & reverse_channel_transmit_out) == 16'h0)
        else $error("resync and reverse transmit both driven on a line");
    a_gate_hides_status: assert property (
        line_read |=> reg_rdata_out[0] || reg_rdata_out[7:4] == 4'h0)
        else $error("status visible on ungated line");
    a_quiet_stable: assert property (
        quiet_bus |-> $stable(terminal_ready_out) && $stable(send_request_out))
        else $error("control output moved without a write");
    a_mux_clear: assert property (
        mux_clr |-> ##2 ctl_any == 16'h0)
        else $error("mux clear left a control output set");
    a_one_line_moves: assert property (
        !$past(mux_clr, 2) |-> $countones(terminal_ready_out
            ^ $past(terminal_ready_out)) <= 1)
        else $error("more than one line changed at once");
    a_done_cleared: assert property (
        $fell(scan_done_out) |-> $past(csr_wr, 2))
        else $error("done dropped without a scan control write");
    a_go_written: assert property (
        $rose(seq_go_out) |-> $past(sys_wr, 2))
        else $error("go rose without a system control write");
endmodule : modem_ctl_asserts
`default_nettype wire

// [testbench/tb.sv]
// Self-checking bench for the per-line modem control and status block
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [15:0] ASYNC = 16'haaaa;
    logic        ref_clk_in = 1'b0;
    logic        sys_rst_in = 1'b1;
    logic [2:0]  reg_sel_in = 3'h0;
    logic        reg_wr_in = 1'b0;
    logic        reg_rd_in = 1'b0;
    logic [15:0] reg_wdata_in = 16'h0;
    logic [15:0] car_on = 16'h0204;
    logic [15:0] ring_on = 16'h0008;
    logic [15:0] rev_on = 16'h0200;
    wire logic [15:0] rdata, dsr, rev_rx, cts, car, ring, seize, sreq, resync, rev_tx;
    wire logic        go;
    wire logic        done;
    int               error_cnt = 0;
    int               checked = 0;

    always #50 ref_clk_in = ~ref_clk_in;

    per_line_modem_control_status uut (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
        .reg_sel_in(reg_sel_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_wdata_in(reg_wdata_in), .reg_rdata_out(rdata), .modem_dsr_in(dsr),
        .modem_reverse_rx_in(rev_rx), .modem_cts_in(cts), .modem_carrier_in(car),
        .modem_ring_in(ring), .line_async_in(ASYNC), .terminal_ready_out(seize),
        .send_request_out(sreq), .carrier_resync_out(resync),
        .reverse_channel_transmit_out(rev_tx), .seq_go_out(go), .scan_done_out(done));
    modem_bank_model modems (.ref_clk_in(ref_clk_in), .terminal_ready_in(seize),
        .send_request_in(sreq), .carrier_on_in(car_on), .ring_on_in(ring_on),
        .reverse_on_in(rev_on), .dsr_out(dsr), .cts_out(cts), .carrier_out(car),
        .ring_out(ring), .reverse_rx_out(rev_rx));

    // ****************************************
    // Bus cycles and comparison
    // ****************************************
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk_in);
    endtask : cyc
    task automatic wr(input logic [2:0] sel, input logic [15:0] data);
        @(negedge ref_clk_in);
        reg_sel_in = sel;
        reg_wdata_in = data;
        reg_wr_in = 1'b1;
        @(negedge ref_clk_in);
        reg_wr_in = 1'b0;
    endtask : wr
    task automatic rd(input logic [2:0] sel, output logic [15:0] data);
        @(negedge ref_clk_in);
        reg_sel_in = sel;
        reg_rd_in = 1'b1;
        @(negedge ref_clk_in);
        reg_rd_in = 1'b0;
        data = rdata;
    endtask : rd
    task automatic wrap_up;
        if (error_cnt == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : wrap_up

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset_values;
        logic [15:0] v;
        rd(3'h1, v);
        chk("line reg after reset", 16'h0, v);
        rd(3'h0, v);
        chk("scan reg after reset", 16'h0, v);
        chk("seized lines after reset", 16'h0, seize | sreq | resync | rev_tx);
    endtask : t_reset_values

    task automatic t_line_controls;
        logic [15:0] v;
        logic [15:0] m;
        logic [3:0]  ln;
        logic [3:0]  st;
        m = 16'h0;
        for (int k = 0; k < 3; k++) begin
            ln = (k == 0) ? 4'h3 : (k == 1) ? 4'h4 : 4'h9;
            m = m | (16'h1 << ln);
            wr(3'h0, {12'h0, ln});
            rd(3'h1, v);
            chk("ungated line reg", 16'h0, v);
            wr(3'h1, 16'h000f);
            cyc(10);
            chk("terminal ready", m, seize);
            chk("send request", m, sreq);
            chk("carrier resync", m & ~ASYNC, resync);
            chk("reverse transmit", m & ASYNC, rev_tx);
            st = {ring_on[ln], car_on[ln], 1'b1, ASYNC[ln] ? rev_on[ln] : 1'b1};
            rd(3'h1, v);
            chk("gated status", {8'h0, st, 4'hf}, v);
            wr(3'h1, 16'h000e);
            cyc(3);
            rd(3'h1, v);
            chk("status after ungating", 16'h000e, v);
        end
    endtask : t_line_controls

    task automatic t_mux_clear;
        logic [15:0] v;
        wr(3'h0, 16'h0405);
        cyc(2);
        chk("controls after mux clear", 16'h0, seize | sreq | resync | rev_tx);
        rd(3'h0, v);
        chk("line kept by mux clear", 16'h0005, v);
        wr(3'h0, 16'h0003);
        rd(3'h1, v);
        chk("line 3 after mux clear", 16'h0, v);
    endtask : t_mux_clear

    task automatic t_scan;
        logic [15:0] v;
        int          n;
        wr(3'h0, 16'h0002);
        wr(3'h1, 16'h0001);
        wr(3'h0, 16'h0800);
        wr(3'h0, 16'h0020);
        n = 0;
        while (done !== 1'b1 && n < 200) begin
            cyc(1);
            n++;
        end
        if (n == 200) begin
            chk("scan done flag", 16'h1, {15'h0, done});
            wrap_up;
        end
        rd(3'h0, v);
        chk("scan reg on carrier change", 16'h40a2, v);
        rd(3'h1, v);
        chk("line reg at stop", 16'h0041, v);
        wr(3'h0, 16'h0022);
        cyc(3);
        chk("done after clear", 16'h0, {15'h0, done});
        wr(3'h0, 16'h0800);
        // A step onto gated line 2 sees carrier as a fresh change
        wr(3'h0, 16'h0001);
        wr(3'h0, 16'h0100);
        rd(3'h0, v);
        chk("scan reg after step", 16'h4082, v);
        wr(3'h0, 16'h0800);
    endtask : t_scan

    task automatic t_misc;
        logic [15:0] v;
        wr(3'h2, 16'h00ff);
        wr(3'h3, 16'h5a3c);
        wr(3'h2, 16'h0000);
        wr(3'h3, 16'h0c3a);
        wr(3'h2, 16'h00ff);
        cyc(2);
        rd(3'h3, v);
        chk("last secondary word", 16'h5a3c, v);
        wr(3'h2, 16'h0000);
        cyc(2);
        rd(3'h3, v);
        chk("first secondary word", 16'h0c3a, v);
        wr(3'h4, 16'h0001);
        cyc(2);
        chk("sequencer go", 16'h1, {15'h0, go});
        wr(3'h5, 16'hffff);
        rd(3'h5, v);
        chk("unmapped select", 16'h0, v);
    endtask : t_misc

    task automatic t_mid_reset;
        logic [15:0] v;
        wr(3'h0, 16'h0007);
        wr(3'h1, 16'h0007);
        cyc(3);
        chk("seizure before init", 16'h0080, seize);
        sys_rst_in = 1'b1;
        cyc(3);
        sys_rst_in = 1'b0;
        cyc(2);
        chk("controls after init", 16'h0, seize | sreq | resync | rev_tx);
        chk("go after init", 16'h0, {15'h0, go});
        wr(3'h0, 16'h0007);
        rd(3'h1, v);
        chk("line reg after init", 16'h0, v);
        // Software reloads a secondary word after the restart
        wr(3'h2, 16'h0010);
        wr(3'h3, 16'h1234);
        cyc(2);
        rd(3'h3, v);
        chk("secondary word after reload", 16'h1234, v);
    endtask : t_mid_reset

    initial begin
        cyc(20);
        sys_rst_in = 1'b0;
        t_reset_values;
        t_line_controls;
        t_mux_clear;
        t_scan;
        t_misc;
        t_mid_reset;
        wrap_up;
    end
endmodule : tb

bind per_line_modem_control_status modem_ctl_asserts #(
    .NUM_LINES(NUM_LINES), .REGS_PER_LINE(REGS_PER_LINE)
) asserts_i (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .reg_sel_in(reg_sel_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(reg_rdata_out), .terminal_ready_out(terminal_ready_out),
    .send_request_out(send_request_out), .carrier_resync_out(carrier_resync_out),
    .reverse_channel_transmit_out(reverse_channel_transmit_out),
    .seq_go_out(seq_go_out), .scan_done_out(scan_done_out));
`default_nettype wire
